// File: design/slip_store_defines.svh
// Operation
// R1 - Cell backplane selected disables both buffers
// R2 - Independent two-frame receive and transmit buffers
// R3 - Each buffer takes its own backplane rate
// R4 - Unlocked clocks: repeat frame empty, delete full
// R5 - Enable bits 0 and 4 insert buffer
// R6 - Min-delay bits 1 and 5 limit depth 32
// R7 - Reset edge puts pointers in opposite frames
// R8 - Software pulses reset/align after clock stable
// R9 - Align edge enforces half-frame pointer separation
// R10 - Software clears align before next align
// R11 - Receive status bits slip, empty, full
// R12 - Transmit status bits slip, empty, full
// R13 - Mask bit per event gates interrupt
// R14 - Backplane drives receive clock at T1/E1 rate
// R15 - Receive sync pin input or boundary output
// R16 - Line frame sync always; multiframe backplane-side
// R17 - T1 on 2.048 clock forces ones, blocks slots
// R18 - E1 on 1.544 deletes slots, inserts F-bit (code inserts F-bit only, deletes no slots)
// R19 - E1 enabled: multiframe sync on backplane output
// R20 - T1 2.048 transmit ignores slots, blocks them
// R21 - Backplane supplies transmit frame/multiframe sync
// R22 - Software sets insertion override when needed
// R23 - Reset delays: receive under frame, transmit over
// R24 - Align delay between half and 1.5 frames
// R25 - Min-delay needs sync output and locked clocks
// R26 - Status latched until cleared, masked to interrupt
`ifndef SLIP_STORE_DEFINES_SVH
`define SLIP_STORE_DEFINES_SVH
`define ADDR_STATUS 8'h1E
`define ADDR_MASK 8'h1F
`define ADDR_CONTROL 8'h4F
`define ADDR_MODE 8'h50
`define RESET_BYTE 8'h00
`define FRAME_BITS 9'd256
`define HALF_FRAME 9'd128
`define MIN_DEPTH 9'd32
`define FULL_DEPTH 9'h1FE
`define RX_RESET_SEP 9'd16
`define TX_RESET_SEP 9'd384
`define ALIGN_SEP 9'd256
`endif

// File: design/slip_store_pkg.sv
package slip_store_pkg;
  typedef struct packed {
    logic txAlign;
    logic txReset;
    logic txMinDelay;
    logic txEnable;
    logic rxAlign;
    logic rxReset;
    logic rxMinDelay;
    logic rxEnable;
  } control_s;
  typedef struct packed {
    logic slip;
    logic empty;
    logic full;
  } slip_s;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } bus_e;
endpackage

// File: design/dual_frame_elastic_store.sv
`timescale 1ns/1ns
`include "slip_store_defines.svh"
module dual_frame_elastic_store
  import slip_store_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rxLineClock,
  input wire logic rxLineData,
  input wire logic rxLineFrame,
  input wire logic rx_system_clock,
  input wire logic rxSyncIn,
  output logic rx_serial_data,
  output logic rx_channel_block,
  output logic rx_line_frame_sync,
  output logic rx_multiframe_sync,
  output logic rxSyncOut,
  input wire logic tx_system_clock,
  input wire logic tx_serial_data,
  input wire logic tx_system_sync_in,
  input wire logic tx_line_clock,
  output logic txLineData,
  output logic tx_channel_block,
  output logic tx_line_sync,
  output logic irq
);
  // ==========================================================
  // Helpers
  function automatic logic [8:0] sep(input logic [8:0] w, input logic [8:0] r);
    sep = w - r;
  endfunction
  function automatic logic blockedSlot(input logic [7:0] bitPos);
    // Every fourth time slot, slot 0 included
    blockedSlot = bitPos[4:3] == 2'b00;
  endfunction

  // ==========================================================
  // Synchronisers
  logic [7:0] sa;
  logic [7:0] sb;
  logic [7:0] sc;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sa <= 8'h00;
      sb <= 8'h00;
      sc <= 8'h00;
    end else begin
      sa <= {rxLineClock, rxLineData, rxLineFrame, rx_system_clock, rxSyncIn,
             tx_system_clock, tx_serial_data, tx_system_sync_in};
      sb <= sa;
      sc <= sb;
    end
  end
  logic rlcRise;
  logic rscRise;
  logic tscRise;
  logic tscFall;
  assign rlcRise = sb[7] & ~sc[7];
  assign rscRise = sb[4] & ~sc[4]; // R3
  assign tscRise = sb[2] & ~sc[2]; // R3
  logic [1:0] tlc;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tlc <= 2'b00;
    end else begin
      tlc <= {tlc[0], tx_line_clock};
    end
  end
  logic tlcSeen;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tlcSeen <= 1'b0;
    end else begin
      tlcSeen <= tlc[1];
    end
  end
  assign tscFall = tlc[1] & ~tlcSeen;

  // ==========================================================
  // Registers
  control_s ctrl;
  control_s ctrlLast;
  logic [7:0] status;
  logic [7:0] mask;
  logic [1:0] mode;
  logic cellBackplane;
  bus_e busState;
  slip_s rxEv;
  slip_s txEv;
  logic clearStatus;
  // Writes land on the edge that sees waitrequest low
  assign clearStatus = busState == BUS_ACK && write && address == `ADDR_STATUS;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busState <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      case (busState)
        BUS_IDLE: begin
          if (read || write) begin
            busState <= BUS_ACK;
            waitrequest <= 1'b0;
            case (address)
              `ADDR_STATUS: readdata <= {24'h00_0000, status};
              `ADDR_MASK: readdata <= {24'h00_0000, mask};
              `ADDR_CONTROL: readdata <= {24'h00_0000, ctrl};
              `ADDR_MODE: readdata <= {29'h0000_0000, cellBackplane, mode};
              default: readdata <= 32'h0000_0000;
            endcase
          end
        end
        BUS_ACK: begin
          busState <= BUS_DONE;
          waitrequest <= 1'b1;
        end
        BUS_DONE: busState <= BUS_IDLE;
        default: busState <= BUS_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `RESET_BYTE;
      mask <= `RESET_BYTE;
      mode <= 2'b00;
      cellBackplane <= 1'b0;
    end else if (clearStatus == 1'b0 && busState == BUS_ACK && write) begin
      if (address == `ADDR_MASK) mask <= {2'b00, writedata[5:0]}; // R13
      if (address == `ADDR_CONTROL) ctrl <= writedata[7:0];
      if (address == `ADDR_MODE) begin
        mode <= writedata[1:0];
        cellBackplane <= writedata[2];
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= `RESET_BYTE;
      irq <= 1'b0;
    end else begin
      // Set wins over write-one-to-clear
      status <= (status & ~(clearStatus ? writedata[7:0] : 8'h00)) |
                {2'b00, txEv.full, txEv.empty, txEv.slip, rxEv.full, rxEv.empty, rxEv.slip}; // R11 R12 R26
      irq <= |(status & mask); // R13 R26
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlLast <= `RESET_BYTE;
    end else begin
      ctrlLast <= ctrl;
    end
  end
  logic rxOn;
  logic txOn;
  assign rxOn = ctrl.rxEnable & ~cellBackplane; // R1 R5
  assign txOn = ctrl.txEnable & ~cellBackplane; // R1 R5

  // ==========================================================
  // Buffers, two frames of 256 bits each
  logic [511:0] rxMem;
  logic [511:0] txMem;
  logic [8:0] rxW;
  logic [8:0] rxR;
  logic [8:0] txW;
  logic [8:0] txR;
  logic [7:0] rxBitOut;
  logic [7:0] txBitIn;
  logic [8:0] rxLimit;
  logic [8:0] txLimit;
  // Without min-delay, full one bit before the writer laps the reader
  assign rxLimit = ctrl.rxMinDelay ? `MIN_DEPTH : `FULL_DEPTH; // R6
  assign txLimit = ctrl.txMinDelay ? `MIN_DEPTH : `FULL_DEPTH; // R6
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxW <= 9'd0;
      rxMem <= '0;
    end else if (rlcRise) begin
      rxMem[rxW] <= sb[6];
      rxW <= rxW + 9'd1;
    end
  end
  // Receive read side, system clock domain sampled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxR <= 9'd0;
      rxBitOut <= 8'd0;
      rxEv <= 3'b000;
    end else begin
      rxEv <= 3'b000;
      if (ctrl.rxReset && !ctrlLast.rxReset) begin
        rxR <= rxW - `RX_RESET_SEP; // R7 R23
      end else if (ctrl.rxAlign && !ctrlLast.rxAlign && sep(rxW, rxR) < `HALF_FRAME) begin
        rxR <= rxW - `ALIGN_SEP; // R9 R24
      end else if (rscRise && rxOn) begin
        rxBitOut <= (sb[3] && !ctrl.rxMinDelay) ? 8'd0 : rxBitOut + 8'd1; // R15
        if (sep(rxW, rxR) == 9'd0) begin
          rxR <= rxR - `FRAME_BITS; // R4
          rxEv <= 3'b110;
        end else if (sep(rxW, rxR) > rxLimit) begin
          rxR <= rxR + `FRAME_BITS; // R4
          rxEv <= 3'b101;
        end else begin
          rxR <= rxR + 9'd1;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_serial_data <= 1'b1;
      rx_channel_block <= 1'b0;
      rx_line_frame_sync <= 1'b0;
      rx_multiframe_sync <= 1'b0;
      rxSyncOut <= 1'b0;
    end else begin
      rx_line_frame_sync <= sb[5]; // R16
      rxSyncOut <= rxOn && rxBitOut == 8'd0;
      rx_multiframe_sync <= rxOn ? rxBitOut == 8'd0 : sb[5]; // R16 R19
      if (!rxOn) begin
        rx_serial_data <= sb[6];
      end else if (mode == 2'b01 && blockedSlot(rxBitOut) && rxBitOut != 8'h00) begin
        rx_serial_data <= 1'b1; // R17
      end else if (mode == 2'b10 && rxBitOut == 8'd0) begin
        rx_serial_data <= 1'b1; // R18
      end else begin
        rx_serial_data <= rxMem[rxR];
      end
      rx_channel_block <= rxOn && mode == 2'b01 && blockedSlot(rxBitOut); // R17
    end
  end
  // Transmit write side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txW <= 9'd0;
      txBitIn <= 8'd0;
      txMem <= '0;
      tx_channel_block <= 1'b0;
    end else if (tscRise && txOn) begin
      txBitIn <= sb[0] ? 8'd0 : txBitIn + 8'd1; // R21
      tx_channel_block <= mode == 2'b01 && blockedSlot(txBitIn); // R20
      if (!(mode == 2'b01 && blockedSlot(txBitIn))) begin
        txMem[txW] <= sb[1]; // R20
        txW <= txW + 9'd1;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txR <= 9'd0;
      txEv <= 3'b000;
      txLineData <= 1'b1;
      tx_line_sync <= 1'b0;
    end else begin
      txEv <= 3'b000;
      if (ctrl.txReset && !ctrlLast.txReset) begin
        txR <= txW - `TX_RESET_SEP; // R7 R23
        txLineData <= 1'b1;
      end else if (ctrl.txAlign && !ctrlLast.txAlign && sep(txW, txR) < `HALF_FRAME) begin
        txR <= txW - `ALIGN_SEP; // R9 R24
      end else if (tscFall) begin
        tx_line_sync <= txR[7:0] == 8'd0;
        if (!txOn) begin
          txLineData <= sb[1];
        end else if (sep(txW, txR) == 9'd0) begin
          txR <= txR - `FRAME_BITS; // R4
          txEv <= 3'b110;
        end else if (sep(txW, txR) > txLimit) begin
          txR <= txR + `FRAME_BITS; // R4
          txEv <= 3'b101;
        end else begin
          txLineData <= txMem[txR];
          txR <= txR + 9'd1;
        end
      end
    end
  end
endmodule

// File: verif/slip_store_sva.sv
`timescale 1ns/1ns
`include "slip_store_defines.svh"
module slip_store_sva
  import slip_store_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic rxLineFrame,
  input wire logic rx_line_frame_sync,
  input wire logic irq
);
  // ==========
  // Shadow registers
  logic [7:0] mask;
  logic [7:0] ctrl;
  logic ack;
  assign ack = !waitrequest;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask <= 8'h00;
    end else if (write && ack && address == `ADDR_MASK) begin
      mask <= writedata[7:0] & 8'h3F;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= 8'h00;
    end else if (write && ack && address == `ADDR_CONTROL) begin
      ctrl <= writedata[7:0];
    end
  end
  property p_ack_one;
    ack |=> waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_latency;
    $rose(read || write) |=> ack;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("ack late");
  property p_idle_gap;
    $rose(waitrequest) |-> waitrequest [*2];
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("idle gap short");
  property p_mask_gate;
    mask == 8'h00 |=> !irq;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("irq unmasked");
  property p_irq_follow;
    read && ack && address == `ADDR_STATUS && (readdata[7:0] & mask) != 0 |-> ##[0:1] irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing");
  property p_rx_slip;
    read && ack && address == `ADDR_STATUS |-> readdata[0] || readdata[2:1] == 2'b00;
  endproperty
  a_rx_slip: assert property (p_rx_slip) else $error("rx slip bit");
  property p_tx_slip;
    read && ack && address == `ADDR_STATUS |-> (readdata[3] || readdata[5:4] == 2'b00)
      && readdata[31:6] == 0;
  endproperty
  a_tx_slip: assert property (p_tx_slip) else $error("tx slip bit");
  property p_ctrl_back;
    read && ack && address == `ADDR_CONTROL |-> readdata == {24'h00_0000, ctrl};
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control readback");
  property p_line_sync;
    $rose(rxLineFrame) |-> ##[1:16] rx_line_frame_sync;
  endproperty
  a_line_sync: assert property (p_line_sync) else $error("line sync missing");
  c_irq: cover property ($rose(irq));
  c_slip: cover property (read && ack && address == `ADDR_STATUS && readdata[0]);
  c_write: cover property (write && ack);
endmodule
bind dual_frame_elastic_store slip_store_sva i_sva (.clk, .rst, .address, .read, .write,
  .writedata, .readdata, .waitrequest, .rxLineFrame, .rx_line_frame_sync, .irq);

// File: verif/backplane_model.sv
`timescale 1ns/1ns
module backplane_model #(
  parameter int RX_PERIOD = 7,
  parameter int TX_PERIOD = 10
) (
  input wire logic clk,
  input wire logic rst,
  output logic rx_system_clock,
  output logic rxSyncIn,
  output logic tx_system_clock,
  output logic tx_system_sync_in,
  output logic tx_serial_data
);
  // ==========
  // Free-running backplane clocks and frame syncs
  int rxCount;
  int rxBits;
  int txCount;
  int txBits;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxCount <= 0;
      rxBits <= 0;
    end else begin
      rxCount <= (rxCount + 1) % RX_PERIOD;
      rxBits <= rxCount == RX_PERIOD - 1 ? (rxBits + 1) % 256 : rxBits;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txCount <= 0;
      txBits <= 0;
    end else begin
      txCount <= (txCount + 1) % TX_PERIOD;
      txBits <= txCount == TX_PERIOD - 1 ? (txBits + 1) % 256 : txBits;
    end
  end
  assign rx_system_clock = rxCount < RX_PERIOD / 2;
  assign tx_system_clock = txCount < TX_PERIOD / 2;
  assign rxSyncIn = rxBits == 0;
  assign tx_system_sync_in = txBits == 0;
  assign tx_serial_data = txBits[1] ^ txBits[4];
endmodule

// File: verif/dual_frame_elastic_store_tb.sv
`timescale 1ns/1ns
`include "slip_store_defines.svh"
module dual_frame_elastic_store_tb
  import slip_store_pkg::*;
;
  // ==========
  // Bench
  logic clk = 0;
  logic rst, read, write, waitrequest, irq;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic rxLineClock, rxLineData, rxLineFrame, rx_system_clock, rxSyncIn, rx_serial_data;
  logic rx_channel_block, rx_line_frame_sync, rx_multiframe_sync, rxSyncOut;
  logic tx_system_clock, tx_serial_data, tx_system_sync_in, tx_line_clock, txLineData;
  logic tx_channel_block, tx_line_sync;
  int failures = 0;
  int cmp_count = 0;
  int lineCount = 0;
  int lineBits = 0;
  int syncCount = 0, mfCount = 0, txSyncCount = 0, rxBlkCount = 0, txBlkCount = 0;
  int baseSync, baseMf, baseTxSync, baseRxBlk, baseTxBlk;
  always #25 clk = ~clk;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lineCount <= 0;
      lineBits <= 0;
    end else begin
      lineCount <= (lineCount + 1) % 8;
      lineBits <= lineCount == 7 ? (lineBits + 1) % 256 : lineBits;
    end
  end
  assign rxLineClock = lineCount < 4;
  assign tx_line_clock = lineCount < 4;
  assign rxLineFrame = lineBits == 0;
  assign rxLineData = lineBits[2] ^ lineBits[5];
  // Output activity counters
  always @(posedge clk) begin
    syncCount <= syncCount + int'(rxSyncOut === 1'b1);
    mfCount <= mfCount + int'(rx_multiframe_sync === 1'b1);
    txSyncCount <= txSyncCount + int'(tx_line_sync === 1'b1);
    rxBlkCount <= rxBlkCount + int'(rx_channel_block === 1'b1);
    txBlkCount <= txBlkCount + int'(tx_channel_block === 1'b1);
  end
  backplane_model i_bp (.clk, .rst, .rx_system_clock, .rxSyncIn, .tx_system_clock,
    .tx_system_sync_in, .tx_serial_data);
  dual_frame_elastic_store i_dut (.clk, .rst, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .rxLineClock, .rxLineData, .rxLineFrame, .rx_system_clock,
    .rxSyncIn, .rx_serial_data, .rx_channel_block, .rx_line_frame_sync, .rx_multiframe_sync,
    .rxSyncOut, .tx_system_clock, .tx_serial_data, .tx_system_sync_in, .tx_line_clock,
    .txLineData, .tx_channel_block, .tx_line_sync, .irq);
  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus_op(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      failures++;
      report_and_stop();
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus_op(a, 1'b0, 8'h00);
    check(q, exp);
  endtask
  initial begin
    rst = 1;
    read = 0;
    write = 0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    rst <= 0;
    @(posedge clk);
    rd(`ADDR_STATUS, 32'h0000_0000);
    rd(`ADDR_MASK, 32'h0000_0000);
    rd(`ADDR_CONTROL, 32'h0000_0000);
    bus_op(8'h20, 1'b1, 8'hAA);
    rd(8'h20, 32'h0000_0000);
    bus_op(`ADDR_MASK, 1'b1, 8'hFF);
    rd(`ADDR_MASK, 32'h0000_003F);
    bus_op(`ADDR_MASK, 1'b1, 8'h00);
    bus_op(`ADDR_MODE, 1'b1, 8'h04);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h11);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h55);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h11);
    baseSync = syncCount;
    repeat (2000) @(posedge clk);
    rd(`ADDR_STATUS, 32'h0000_0000);
    check(syncCount - baseSync, 32'h0000_0000);
    bus_op(`ADDR_MODE, 1'b1, 8'h00);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h55);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h11);
    rd(`ADDR_CONTROL, 32'h0000_0011);
    baseSync = syncCount;
    baseMf = mfCount;
    baseTxSync = txSyncCount;
    baseRxBlk = rxBlkCount;
    for (int i = 0; i < 150 && (q[0] !== 1'b1 || q[3] !== 1'b1); i++) begin
      repeat (200) @(posedge clk);
      bus_op(`ADDR_STATUS, 1'b0, 8'h00);
    end
    check(q, 32'h0000_001B);
    check({31'h0000_0000, syncCount > baseSync}, 32'h0000_0001);
    check({31'h0000_0000, mfCount > baseMf}, 32'h0000_0001);
    check({31'h0000_0000, txSyncCount > baseTxSync}, 32'h0000_0001);
    check(rxBlkCount - baseRxBlk, 32'h0000_0000);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    bus_op(`ADDR_MASK, 1'b1, 8'h01);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h00);
    bus_op(`ADDR_STATUS, 1'b1, 8'hFF);
    rd(`ADDR_STATUS, 32'h0000_0000);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h55);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h99);
    bus_op(`ADDR_CONTROL, 1'b1, 8'h11);
    repeat (2000) @(posedge clk);
    rd(`ADDR_STATUS, 32'h0000_0000);
    bus_op(`ADDR_MODE, 1'b1, 8'h01);
    baseRxBlk = rxBlkCount;
    baseTxBlk = txBlkCount;
    repeat (2000) @(posedge clk);
    check({31'h0000_0000, rxBlkCount > baseRxBlk}, 32'h0000_0001);
    check({31'h0000_0000, txBlkCount > baseTxBlk}, 32'h0000_0001);
    report_and_stop();
  end
endmodule
